/* File: verilog/sst_i2c_slave_tx.sv */
`timescale 1ns/1ps
// Operation
// - a matching address with the read bit set sets the read flag, loads the address into the transfer buffer and is acknowledged on the ninth bit.
// - after that acknowledge the clock release bit is cleared and SCL is held low.
// - a transmit write loads buffer and shift register together, and setting the clock release bit frees SCL.
// - the first data bit goes out as SCL is freed and later bits change on falling SCL edges, so SDA is stable while SCL is high.
// - the master acknowledge is sampled on the ninth rising SCL edge into the acknowledge status bit.
// - a not-acknowledge ends the transfer and the slave waits for a new Start.
// - the port interrupt flag is set on the ninth falling SCL edge of each byte and cleared by software.
// - a collision while shifting data out with slave detection enabled sets the collision flag and idles the slave.
// - a Start sets the start-seen flag and raises the port interrupt flag only when Start interrupts are enabled.
// - reading the received address from the transfer buffer clears the buffer full flag.
// - in a Repeated Start, SCL falling before the rate generator expires with SDA not driven low is a collision.
// - in a Repeated Start, SCL and SDA high at expiry drive SDA low and reload, and the next expiry drives SCL low.
// - in a Stop, SDA still low at expiry after being released is a collision.
// - in a Stop, SCL sampled low after its release and before SDA rises is a collision.
// - a Stop drives SDA low, releases SCL once SDA reads low, and loads the rate generator once SCL reads high.
module sst_i2c_slave_tx #(
    parameter int unsigned ADDR_W = sst_pkg::SST_ADDR_W,
    parameter int unsigned RATE_W = sst_pkg::SST_RATE_W
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // two-wire bus pins
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe_n,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    // configuration
    input wire logic [ADDR_W-1:0] i_own_addr,
    input wire logic i_slave_collision_detect_en,
    input wire logic i_start_irq_en,
    input wire logic [RATE_W-1:0] i_rate_reload_reg,
    // software strobes
    input wire logic i_buf_wr,
    input wire logic [7:0] i_buf_wdata,
    input wire logic i_buf_rd,
    input wire logic i_clock_release_set,
    input wire logic i_irq_clr,
    input wire logic i_bcl_clr,
    input wire logic i_rstart_req,
    input wire logic i_stop_req,
    // status
    output logic [7:0] o_transfer_buffer,
    output logic o_buffer_full_flag,
    output logic o_read_write,
    output logic o_ack_status_bit,
    output logic o_clock_release_bit,
    output logic o_port_irq_flag,
    output logic o_bus_collision_flag,
    output logic o_start_seen,
    output logic o_master_busy
);

    generate
        if (ADDR_W != 7 || RATE_W < 2 || RATE_W > 16)
        begin : g_chk
            $error("sst_i2c_slave_tx: unsupported ADDR_W or RATE_W");
        end
    endgenerate

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], i_scl};
            sda_sync_r <= {sda_sync_r[0], i_sda};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & ~sda_s & sda_d_r;
    assign stop_det = scl_s & scl_d_r & sda_s & ~sda_d_r;

    // ************************************************************
    // state
    // ************************************************************
    sst_pkg::sst_slv_type slv_r, slv_nxt;
    sst_pkg::sst_mst_type mst_r, mst_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] buf_r, buf_nxt;
    logic [RATE_W-1:0] rate_r, rate_nxt;
    logic bf_r, bf_nxt;
    logic rw_r, rw_nxt;
    logic ack_r, ack_nxt;
    logic ckp_r, ckp_nxt;
    logic irq_r, irq_nxt;
    logic bcl_r, bcl_nxt;
    logic sseen_r, sseen_nxt;
    logic s_scl_low_r, s_scl_low_nxt;
    logic s_sda_low_r, s_sda_low_nxt;
    logic m_scl_low_r, m_scl_low_nxt;
    logic m_sda_low_r, m_sda_low_nxt;
    logic scl_oe_n_r, sda_oe_n_r;
    logic busy_r;
    logic irq_set, bcl_set, bf_set, bf_clr, ckp_clr;
    logic rate_exp;

    assign rate_exp = (rate_r == '0);

    always_comb
    begin
        slv_nxt = slv_r;
        mst_nxt = mst_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        buf_nxt = buf_r;
        rw_nxt = rw_r;
        ack_nxt = ack_r;
        s_scl_low_nxt = s_scl_low_r;
        s_sda_low_nxt = s_sda_low_r;
        m_scl_low_nxt = m_scl_low_r;
        m_sda_low_nxt = m_sda_low_r;
        rate_nxt = rate_exp ? rate_r : rate_r - 1'b1;
        irq_set = 1'b0;
        bcl_set = 1'b0;
        bf_set = 1'b0;
        bf_clr = 1'b0;
        ckp_clr = 1'b0;
        sseen_nxt = sseen_r;

        if (i_buf_wr)
        begin
            buf_nxt = i_buf_wdata;
            shift_nxt = i_buf_wdata;
            bf_set = 1'b1;
        end

        // ********************************************************
        // slave transmit
        // ********************************************************
        if (stop_det)
        begin
            sseen_nxt = 1'b0;
            slv_nxt = sst_pkg::SST_S_IDLE;
            s_scl_low_nxt = 1'b0;
            s_sda_low_nxt = 1'b0;
        end
        else if (start_det && mst_r == sst_pkg::SST_M_IDLE)
        begin
            sseen_nxt = 1'b1;
            irq_set = i_start_irq_en;
            slv_nxt = sst_pkg::SST_S_ADDR;
            cnt_nxt = sst_pkg::SST_CNT_RST;
            s_scl_low_nxt = 1'b0;
            s_sda_low_nxt = 1'b0;
        end
        else
        begin
            case (slv_r)
                sst_pkg::SST_S_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 1'b1;
                    end
                    else if (scl_fall && cnt_r == sst_pkg::SST_ADDR_BITS)
                    begin
                        if (shift_r[7:1] == i_own_addr && shift_r[0])
                        begin
                            rw_nxt = 1'b1;
                            buf_nxt = shift_r;
                            bf_set = 1'b1;
                            s_sda_low_nxt = 1'b1;
                            slv_nxt = sst_pkg::SST_S_AACK;
                        end
                        else
                        begin
                            // write requests and other addresses are not served here
                            slv_nxt = sst_pkg::SST_S_IDLE;
                        end
                    end
                end
                sst_pkg::SST_S_AACK:
                begin
                    if (scl_fall)
                    begin
                        s_sda_low_nxt = 1'b0;
                        s_scl_low_nxt = 1'b1;
                        ckp_clr = 1'b1;
                        irq_set = 1'b1;
                        slv_nxt = sst_pkg::SST_S_HOLD;
                    end
                end
                sst_pkg::SST_S_HOLD:
                begin
                    // first bit goes out on the same core clock edge that frees SCL
                    if (ckp_r)
                    begin
                        s_scl_low_nxt = 1'b0;
                        s_sda_low_nxt = ~shift_nxt[7];
                        cnt_nxt = sst_pkg::SST_CNT_RST;
                        slv_nxt = sst_pkg::SST_S_TX;
                    end
                end
                sst_pkg::SST_S_TX:
                begin
                    if (scl_rise && i_slave_collision_detect_en && !s_sda_low_r && !sda_s)
                    begin
                        bcl_set = 1'b1;
                        s_sda_low_nxt = 1'b0;
                        slv_nxt = sst_pkg::SST_S_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        cnt_nxt = cnt_r + 1'b1;
                        if (cnt_r == sst_pkg::SST_LAST_BIT)
                        begin
                            s_sda_low_nxt = 1'b0;
                            bf_clr = 1'b1;
                            slv_nxt = sst_pkg::SST_S_MACK;
                        end
                        else
                        begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            s_sda_low_nxt = ~shift_r[6];
                        end
                    end
                end
                sst_pkg::SST_S_MACK:
                begin
                    if (scl_rise)
                    begin
                        ack_nxt = sda_s;
                    end
                    else if (scl_fall)
                    begin
                        irq_set = 1'b1;
                        if (ack_r)
                        begin
                            slv_nxt = sst_pkg::SST_S_IDLE;
                        end
                        else
                        begin
                            // software reloads and releases again
                            s_scl_low_nxt = 1'b1;
                            ckp_clr = 1'b1;
                            slv_nxt = sst_pkg::SST_S_HOLD;
                        end
                    end
                end
                default:
                begin
                    s_scl_low_nxt = 1'b0;
                    s_sda_low_nxt = 1'b0;
                end
            endcase
        end

        // ********************************************************
        // master repeated start and stop
        // ********************************************************
        case (mst_r)
            sst_pkg::SST_M_IDLE:
            begin
                if (i_rstart_req)
                begin
                    m_sda_low_nxt = 1'b0;
                    m_scl_low_nxt = 1'b0;
                    mst_nxt = sst_pkg::SST_M_RS_REL;
                end
                else if (i_stop_req)
                begin
                    m_sda_low_nxt = 1'b1;
                    mst_nxt = sst_pkg::SST_M_SP_LOW;
                end
            end
            sst_pkg::SST_M_RS_REL:
            begin
                if (scl_s)
                begin
                    rate_nxt = i_rate_reload_reg;
                    mst_nxt = sst_pkg::SST_M_RS_T1;
                end
            end
            sst_pkg::SST_M_RS_T1:
            begin
                if (scl_fall || (rate_exp && !(scl_s && sda_s)))
                begin
                    bcl_set = 1'b1;
                    mst_nxt = sst_pkg::SST_M_IDLE;
                end
                else if (rate_exp)
                begin
                    m_sda_low_nxt = 1'b1;
                    rate_nxt = i_rate_reload_reg;
                    mst_nxt = sst_pkg::SST_M_RS_T2;
                end
            end
            sst_pkg::SST_M_RS_T2:
            begin
                if (rate_exp)
                begin
                    m_scl_low_nxt = 1'b1;
                    mst_nxt = sst_pkg::SST_M_IDLE;
                end
            end
            sst_pkg::SST_M_SP_LOW:
            begin
                if (!sda_s)
                begin
                    m_scl_low_nxt = 1'b0;
                    mst_nxt = sst_pkg::SST_M_SP_REL;
                end
            end
            sst_pkg::SST_M_SP_REL:
            begin
                if (scl_s)
                begin
                    rate_nxt = i_rate_reload_reg;
                    mst_nxt = sst_pkg::SST_M_SP_T1;
                end
            end
            sst_pkg::SST_M_SP_T1:
            begin
                if (!scl_s)
                begin
                    bcl_set = 1'b1;
                    mst_nxt = sst_pkg::SST_M_IDLE;
                end
                else if (rate_exp)
                begin
                    m_sda_low_nxt = 1'b0;
                    rate_nxt = i_rate_reload_reg;
                    mst_nxt = sst_pkg::SST_M_SP_T2;
                end
            end
            sst_pkg::SST_M_SP_T2:
            begin
                if (!scl_s && !sda_s)
                begin
                    bcl_set = 1'b1;
                    mst_nxt = sst_pkg::SST_M_IDLE;
                end
                else if (rate_exp)
                begin
                    bcl_set = ~sda_s;
                    mst_nxt = sst_pkg::SST_M_IDLE;
                end
            end
            default:
            begin
                mst_nxt = sst_pkg::SST_M_IDLE;
            end
        endcase
        if (bcl_set && mst_r != sst_pkg::SST_M_IDLE)
        begin
            m_scl_low_nxt = 1'b0;
            m_sda_low_nxt = 1'b0;
        end

        // hardware set wins over a software clear in the same cycle
        irq_nxt = (irq_r & ~i_irq_clr) | irq_set;
        bcl_nxt = (bcl_r & ~i_bcl_clr) | bcl_set;
        bf_nxt = (bf_r & ~(i_buf_rd | bf_clr)) | bf_set;
        ckp_nxt = (ckp_r & ~ckp_clr) | i_clock_release_set;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            slv_r <= sst_pkg::SST_S_IDLE;
            mst_r <= sst_pkg::SST_M_IDLE;
            cnt_r <= sst_pkg::SST_CNT_RST;
            shift_r <= sst_pkg::SST_BYTE_RST;
            buf_r <= sst_pkg::SST_BYTE_RST;
            rate_r <= '0;
            bf_r <= 1'b0;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            ckp_r <= 1'b1;
            irq_r <= 1'b0;
            bcl_r <= 1'b0;
            sseen_r <= 1'b0;
            s_scl_low_r <= 1'b0;
            s_sda_low_r <= 1'b0;
            m_scl_low_r <= 1'b0;
            m_sda_low_r <= 1'b0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            busy_r <= 1'b0;
        end
        else
        begin
            slv_r <= slv_nxt;
            mst_r <= mst_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            buf_r <= buf_nxt;
            rate_r <= rate_nxt;
            bf_r <= bf_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            ckp_r <= ckp_nxt;
            irq_r <= irq_nxt;
            bcl_r <= bcl_nxt;
            sseen_r <= sseen_nxt;
            s_scl_low_r <= s_scl_low_nxt;
            s_sda_low_r <= s_sda_low_nxt;
            m_scl_low_r <= m_scl_low_nxt;
            m_sda_low_r <= m_sda_low_nxt;
            scl_oe_n_r <= ~(s_scl_low_nxt | m_scl_low_nxt);
            sda_oe_n_r <= ~(s_sda_low_nxt | m_sda_low_nxt);
            // registered so it moves on the same edge as the master state
            busy_r <= (mst_nxt != sst_pkg::SST_M_IDLE);
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // open drain: only a low level is ever driven
    assign o_scl = 1'b0;
    assign o_sda = 1'b0;
    assign o_scl_oe_n = scl_oe_n_r;
    assign o_sda_oe_n = sda_oe_n_r;
    assign o_transfer_buffer = buf_r;
    assign o_buffer_full_flag = bf_r;
    assign o_read_write = rw_r;
    assign o_ack_status_bit = ack_r;
    assign o_clock_release_bit = ckp_r;
    assign o_port_irq_flag = irq_r;
    assign o_bus_collision_flag = bcl_r;
    assign o_start_seen = sseen_r;
    assign o_master_busy = busy_r;

endmodule

/* File: verilog/sst_pkg.sv */
package sst_pkg;

    // ************************************************************
    // widths and fixed counts
    // ************************************************************
    localparam int unsigned SST_DATA_W = 8;
    localparam int unsigned SST_ADDR_W = 7;
    localparam int unsigned SST_RATE_W = 8;
    localparam int unsigned SST_CNT_W = 4;
    localparam logic [3:0] SST_ADDR_BITS = 4'h8;
    localparam logic [3:0] SST_LAST_BIT = 4'h7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] SST_BYTE_RST = 8'h00;
    localparam logic [3:0] SST_CNT_RST = 4'h0;

    // ************************************************************
    // slave transmit states
    // ************************************************************
    typedef enum logic [5:0] {
        SST_S_IDLE = 6'h01,
        SST_S_ADDR = 6'h02,
        SST_S_AACK = 6'h04,
        SST_S_HOLD = 6'h08,
        SST_S_TX   = 6'h10,
        SST_S_MACK = 6'h20
    } sst_slv_type;

    // ************************************************************
    // master repeated start / stop states
    // ************************************************************
    typedef enum logic [7:0] {
        SST_M_IDLE   = 8'h01,
        SST_M_RS_REL = 8'h02,
        SST_M_RS_T1  = 8'h04,
        SST_M_RS_T2  = 8'h08,
        SST_M_SP_LOW = 8'h10,
        SST_M_SP_REL = 8'h20,
        SST_M_SP_T1  = 8'h40,
        SST_M_SP_T2  = 8'h80
    } sst_mst_type;

endpackage

/* File: dv/sst_props.sv */
`timescale 1ns/1ps
module sst_props (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // inputs
    input wire logic i_scl,
    input wire logic i_start_irq_en,
    input wire logic i_slave_collision_detect_en,
    input wire logic i_buf_wr,
    input wire logic [7:0] i_buf_wdata,
    input wire logic i_buf_rd,
    input wire logic i_stop_req,
    input wire logic i_rstart_req,
    // outputs
    input wire logic o_scl_oe_n,
    input wire logic o_sda_oe_n,
    input wire logic [7:0] o_transfer_buffer,
    input wire logic o_buffer_full_flag,
    input wire logic o_clock_release_bit,
    input wire logic o_port_irq_flag,
    input wire logic o_bus_collision_flag,
    input wire logic o_start_seen,
    input wire logic o_master_busy
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    // ********************
    // properties
    // ********************
    property p_buf_load;
        i_buf_wr |=> o_transfer_buffer == $past(i_buf_wdata) && o_buffer_full_flag;
    endproperty
    a_buf_load: assert property (p_buf_load) else $error("buffer load lost");
    property p_bf_rd;
        i_buf_rd && !i_buf_wr |=> !o_buffer_full_flag;
    endproperty
    a_bf_rd: assert property (p_bf_rd) else $error("buffer full not cleared");
    property p_hold;
        $fell(o_clock_release_bit) |-> ##[0:2] !o_scl_oe_n;
    endproperty
    a_hold: assert property (p_hold) else $error("clock not stretched");
    property p_start_irq;
        $rose(o_start_seen) && i_start_irq_en |-> ##[0:1] o_port_irq_flag;
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("start irq missing");
    property p_bcl_en;
        $rose(o_bus_collision_flag) && !$past(o_master_busy) |-> i_slave_collision_detect_en;
    endproperty
    a_bcl_en: assert property (p_bcl_en) else $error("slave collision while off");
    property p_bcl_rel;
        $rose(o_bus_collision_flag) |-> ##[0:1] (o_scl_oe_n && o_sda_oe_n);
    endproperty
    a_bcl_rel: assert property (p_bcl_rel) else $error("lines kept after collision");
    property p_rs_done;
        $fell(o_master_busy) && !o_bus_collision_flag && !o_sda_oe_n |-> !o_scl_oe_n;
    endproperty
    a_rs_done: assert property (p_rs_done) else $error("restart left clock free");
    property p_stop_sda;
        i_stop_req && !i_rstart_req && !o_master_busy |-> ##[1:3] !o_sda_oe_n;
    endproperty
    a_stop_sda: assert property (p_stop_sda) else $error("stop without data low");
    // slave data may only move while the clock wire is low
    property p_sda_stable;
        $changed(o_sda_oe_n) && !o_master_busy && !$past(o_master_busy)
            && !$past(o_master_busy, 2) |-> !$past(i_scl, 2);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("data moved in clock high");
    c_stretch: cover property ($fell(o_clock_release_bit));
    c_bcl: cover property ($rose(o_bus_collision_flag));
    c_rs: cover property ($fell(o_master_busy) && !o_sda_oe_n);
endmodule

/* File: dv/sst_bus_master.sv */
`timescale 1ns/1ps
module sst_bus_master #(
    // a quarter of the 48 ns link clock period
    parameter int HALF_NS = 12
) (
    // clock and wire levels
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // open-drain releases, 1 lets the pull-up win
    output logic o_scl_rel,
    output logic o_sda_rel
);
    // ********************
    // bus primitives
    // ********************
    initial
    begin
        o_scl_rel = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic half();
        #(HALF_NS);
    endtask
    task automatic start();
        o_sda_rel = 1'b0;
        half();
        o_scl_rel = 1'b0;
        half();
    endtask
    task automatic stop();
        o_sda_rel = 1'b0;
        half();
        o_scl_rel = 1'b1;
        half();
        o_sda_rel = 1'b1;
        half();
        // let the slave's synchroniser see the stop before anyone looks
        repeat (4) @(negedge i_clk);
    endtask
    // a stretched clock is waited out, bounded so a stuck slave cannot hang us
    task automatic bit_x(input logic b, output logic r);
        int n;
        o_sda_rel = b;
        half();
        o_scl_rel = 1'b1;
        n = 0;
        while (i_scl !== 1'b1 && n < 20000)
        begin
            @(negedge i_clk);
            n++;
        end
        half();
        r = i_sda;
        half();
        o_scl_rel = 1'b0;
        half();
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic r);
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], q[i]);
        end
        bit_x(a, r);
        // clock stays low here; slave flags settle three core clocks after the fall
        repeat (4) @(negedge i_clk);
    endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic m_scl, m_sda, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n;
    logic [6:0] i_own_addr = 7'h2B;
    logic i_slave_collision_detect_en = 1'b0;
    logic i_start_irq_en = 1'b1;
    logic [7:0] i_rate_reload_reg = 8'h30;
    logic [7:0] i_buf_wdata = 8'h00;
    logic i_buf_wr = 1'b0, i_buf_rd = 1'b0, i_clock_release_set = 1'b0;
    logic i_irq_clr = 1'b0, i_bcl_clr = 1'b0, i_rstart_req = 1'b0, i_stop_req = 1'b0;
    logic [7:0] o_transfer_buffer;
    logic o_buffer_full_flag, o_read_write, o_ack_status_bit, o_clock_release_bit;
    logic o_port_irq_flag, o_bus_collision_flag, o_start_seen, o_master_busy;
    logic [7:0] q;
    logic r;
    int err_count = 0;
    int num_checks = 0;
    wire i_scl = m_scl & (o_scl_oe_n | o_scl);
    wire i_sda = m_sda & (o_sda_oe_n | o_sda);
    always #2.5 i_core_clk = ~i_core_clk;
    sst_i2c_slave_tx u_sst_i2c_slave_tx (.*);
    sst_bus_master u_sst_bus_master (.i_clk(i_core_clk), .i_scl(i_scl), .i_sda(i_sda),
        .o_scl_rel(m_scl), .o_sda_rel(m_sda));
    // ********************
    // helpers
    // ********************
    task automatic pulse(ref logic s);
        @(negedge i_core_clk);
        s = 1'b1;
        @(negedge i_core_clk);
        s = 1'b0;
    endtask
    task automatic sw_next(input logic [7:0] d);
        pulse(i_irq_clr);
        i_buf_wdata = d;
        pulse(i_buf_wr);
        pulse(i_clock_release_set);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(negedge i_core_clk);
        while (o_master_busy !== 1'b0 && n < 2000)
        begin
            @(negedge i_core_clk);
            n++;
        end
        `CHK(o_master_busy, 1'b0)
    endtask
    task automatic close_out();
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic t_read();
        u_sst_bus_master.start();
        `CHK({o_start_seen, o_port_irq_flag}, 2'b11)
        pulse(i_irq_clr);
        u_sst_bus_master.xfer({i_own_addr, 1'b1}, 1'b1, q, r);
        `CHK(r, 1'b0)
        `CHK({o_transfer_buffer, o_read_write}, {i_own_addr, 1'b1, 1'b1})
        `CHK({o_port_irq_flag, o_clock_release_bit, i_scl}, 3'b100)
        pulse(i_buf_rd);
        `CHK(o_buffer_full_flag, 1'b0)
        sw_next(8'hA5);
        u_sst_bus_master.xfer(8'hFF, 1'b0, q, r);
        `CHK(q, 8'hA5)
        `CHK({o_ack_status_bit, o_port_irq_flag}, 2'b01)
        sw_next(8'h3C);
        u_sst_bus_master.xfer(8'hFF, 1'b1, q, r);
        `CHK({q, o_ack_status_bit}, {8'h3C, 1'b1})
        // slave must have gone idle, so nothing is driven now
        u_sst_bus_master.xfer(8'hFF, 1'b1, q, r);
        `CHK(q, 8'hFF)
        u_sst_bus_master.stop();
        `CHK(o_start_seen, 1'b0)
    endtask
    task automatic t_refuse();
        i_start_irq_en = 1'b0;
        pulse(i_irq_clr);
        u_sst_bus_master.start();
        `CHK({o_start_seen, o_port_irq_flag}, 2'b10)
        u_sst_bus_master.xfer({i_own_addr ^ 7'h01, 1'b1}, 1'b1, q, r);
        `CHK(r, 1'b1)
        u_sst_bus_master.stop();
    endtask
    task automatic t_slv_bcl();
        i_slave_collision_detect_en = 1'b1;
        u_sst_bus_master.start();
        u_sst_bus_master.xfer({i_own_addr, 1'b1}, 1'b1, q, r);
        pulse(i_buf_rd);
        sw_next(8'h80);
        u_sst_bus_master.xfer(8'h7F, 1'b1, q, r);
        `CHK({o_bus_collision_flag, o_sda_oe_n, o_scl_oe_n}, 3'b111)
        u_sst_bus_master.stop();
        pulse(i_bcl_clr);
        `CHK(o_bus_collision_flag, 1'b0)
    endtask
    task automatic t_rs_stop();
        pulse(i_rstart_req);
        wait_idle();
        `CHK({o_bus_collision_flag, o_scl_oe_n, o_sda_oe_n}, 3'b000)
        pulse(i_stop_req);
        wait_idle();
        `CHK({o_bus_collision_flag, o_scl_oe_n, o_sda_oe_n}, 3'b011)
    endtask
    // kind 0: clock pulled early in a restart, 1: data held in a stop, 2: clock in a stop
    task automatic t_m_bcl(input int kind);
        if (kind == 0)
            pulse(i_rstart_req);
        else
            pulse(i_stop_req);
        if (kind == 1)
            u_sst_bus_master.o_sda_rel = 1'b0;
        else
        begin
            repeat (15) @(negedge i_core_clk);
            u_sst_bus_master.o_scl_rel = 1'b0;
            repeat (10) @(negedge i_core_clk);
            u_sst_bus_master.o_scl_rel = 1'b1;
        end
        wait_idle();
        u_sst_bus_master.o_sda_rel = 1'b1;
        `CHK(o_bus_collision_flag, 1'b1)
        `CHK({o_scl_oe_n, o_sda_oe_n}, 2'b11)
        pulse(i_bcl_clr);
        repeat (40) @(negedge i_core_clk);
    endtask
    initial
    begin
        repeat (8) @(negedge i_core_clk);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_core_clk);
        `CHK({o_scl_oe_n, o_sda_oe_n, o_clock_release_bit, o_port_irq_flag}, 4'hE)
        `CHK({o_buffer_full_flag, o_transfer_buffer}, 9'h000)
        t_read();
        t_refuse();
        t_slv_bcl();
        t_rs_stop();
        for (int k = 0; k < 3; k++)
        begin
            t_m_bcl(k);
        end
        close_out();
    end
    initial
    begin
        #100000;
        err_count++;
        close_out();
    end
endmodule
bind sst_i2c_slave_tx sst_props u_sst_props (.*);
